/* File: core/afe_slot_cfg_defines.vh */
// constants for the slot timing and mode configuration bank
// assumes: included by the bank module and by the bench top, which uses its addresses and reset values
`ifndef AFE_SLOT_CFG_DEFINES_VH
`define AFE_SLOT_CFG_DEFINES_VH

// ****************************************
// register addresses
// ****************************************
`define ADDR_WINDOW 8'h39
`define ADDR_CHAIN 8'h42
`define ADDR_INT_ENABLE 8'h58
`define ADDR_INT_OPTIONS 8'h5A

// ****************************************
// reset values
// ****************************************
`define RST_WINDOW 16'h22FC
`define RST_CHAIN 16'h1C38
`define RST_INT_ENABLE 16'h0000
`define RST_INT_OPTIONS 16'h0000

// ****************************************
// field positions
// ****************************************
`define WIDTH_MSB 15
`define WIDTH_LSB 11
`define COARSE_MSB 10
`define COARSE_LSB 5
`define FINE_MSB 4
`define FINE_LSB 0
`define MODE_MSB 15
`define MODE_LSB 8
`define IND_GAIN_BIT 6
`define GAIN_MSB 1
`define GAIN_LSB 0
`define SECOND_INT_BIT 13
`define FIRST_INT_BIT 12
`define GAP_BIT 7
`define SECOND_PAIR_BIT 6
`define FIRST_PAIR_BIT 5

// ****************************************
// chain mode codes and gain scale
// ****************************************
`define CHAIN_NORMAL 8'h1C
`define CHAIN_DIGITAL 8'h1D
`define GAIN_BASE_KOHM 8'hC8

// ****************************************
// serial port constants
// ****************************************
`define BITS_PER_BYTE 4'h8
`define LAST_TX_BIT 4'h7

`endif

/* File: core/afe_slot_timing_mode_config.v */
// serial-port register bank for per-slot acquisition timing and mode
// assumes: scl and sda inputs already synchronous to the system clock;
// the bus wire is resolved outside from the open-drain enable
`timescale 1ns/1ps
`include "afe_slot_cfg_defines.vh"

module afe_slot_timing_mode_config #(
    parameter [6:0] DEV_ADDR = 7'h2A // arbitrary default bus address
) (
    // clock and reset
    input wire I_SYS_CLK,
    input wire I_RST_N,
    // serial register port
    input wire I_SCL,
    input wire I_SDA,
    output wire O_SDA_OUT,
    output wire O_SDA_OE_N,
    // outside gain fields and second slot fine delay
    input wire [5:0] I_FIRST_SLOT_CH_GAIN,
    input wire [4:0] I_SECOND_SLOT_WINDOW_FINE_DELAY,
    // slot mode selects
    output wire O_FIRST_SLOT_INTEGRATE_SELECT,
    output wire O_SECOND_SLOT_INTEGRATE_SELECT,
    output wire O_FIRST_SLOT_PAIR_COUNT_SELECT,
    output wire O_SECOND_SLOT_PAIR_COUNT_SELECT,
    output wire O_INTEGRATE_GAP_ENABLE,
    output wire [4:0] O_FIRST_SLOT_GAP_US,
    output wire [4:0] O_SECOND_SLOT_GAP_US,
    // first slot window
    output wire [4:0] O_FIRST_SLOT_WINDOW_WIDTH,
    output wire [10:0] O_FIRST_SLOT_WINDOW_START,
    // first slot chain and gains
    output wire [7:0] O_FIRST_SLOT_CHAIN_MODE,
    output wire O_FIRST_SLOT_CHAIN_NORMAL,
    output wire O_FIRST_SLOT_CHAIN_DIGITAL,
    output wire [7:0] O_CH1_GAIN_KOHM,
    output wire [7:0] O_CH2_GAIN_KOHM,
    output wire [7:0] O_CH3_GAIN_KOHM,
    output wire [7:0] O_CH4_GAIN_KOHM
);

    // ****************************************
    // port engine states
    // ****************************************
    localparam [2:0] ST_IDLE = 3'h0;
    localparam [2:0] ST_ADDR = 3'h1;
    localparam [2:0] ST_ACK = 3'h2;
    localparam [2:0] ST_RX = 3'h3;
    localparam [2:0] ST_TX = 3'h4;
    localparam [2:0] ST_MACK = 3'h5;

    reg [15:0] window_reg, chain_reg, int_enable_reg, int_options_reg;
    reg scl_reg, sda_reg, scl_prev_reg, sda_prev_reg;
    reg [2:0] state_reg;
    reg [3:0] bit_cnt_reg;
    reg [7:0] shift_reg, pointer_reg, hold_hi_reg;
    reg rw_reg, lo_sent_reg, sda_oe_n_reg;
    reg [1:0] byte_idx_reg;

    wire scl_rise, scl_fall, bus_start, bus_stop;
    wire [15:0] rd_word, rd_next_word;
    wire [7:0] pointer_next;

    // ****************************************
    // read mux, unmapped addresses read zero
    // ****************************************
    function [15:0] read_word;
        input [7:0] addr;
        input [15:0] w0;
        input [15:0] w1;
        input [15:0] w2;
        input [15:0] w3;
        begin
            case (addr)
                `ADDR_WINDOW: read_word = w0;
                `ADDR_CHAIN: read_word = w1;
                `ADDR_INT_ENABLE: read_word = w2;
                `ADDR_INT_OPTIONS: read_word = w3;
                default: read_word = 16'h0000;
            endcase
        end
    endfunction

    // gain code to kilohm, halves per step
    function [7:0] gain_kohm;
        input [1:0] code;
        begin
            gain_kohm = `GAIN_BASE_KOHM >> code;
        end
    endfunction

    // ****************************************
    // bus pin sampling and event detect
    // ****************************************
    always @(posedge I_SYS_CLK or negedge I_RST_N) begin
        if (!I_RST_N) begin
            scl_reg <= 1'b1;
            sda_reg <= 1'b1;
            scl_prev_reg <= 1'b1;
            sda_prev_reg <= 1'b1;
        end else begin
            scl_reg <= I_SCL;
            sda_reg <= I_SDA;
            scl_prev_reg <= scl_reg;
            sda_prev_reg <= sda_reg;
        end
    end

    // edges and start or stop conditions
    assign scl_rise = scl_reg & ~scl_prev_reg;
    assign scl_fall = ~scl_reg & scl_prev_reg;
    assign bus_start = scl_reg & scl_prev_reg & sda_prev_reg & ~sda_reg;
    assign bus_stop = scl_reg & scl_prev_reg & ~sda_prev_reg & sda_reg;
    assign pointer_next = pointer_reg + 8'h01;
    assign rd_word = read_word(pointer_reg, window_reg, chain_reg, int_enable_reg,
        int_options_reg);
    assign rd_next_word = read_word(pointer_next, window_reg, chain_reg, int_enable_reg,
        int_options_reg);

    // ****************************************
    // serial engine and register storage
    // ****************************************
    always @(posedge I_SYS_CLK or negedge I_RST_N) begin
        if (!I_RST_N) begin
            window_reg <= `RST_WINDOW;
            chain_reg <= `RST_CHAIN;
            int_enable_reg <= `RST_INT_ENABLE;
            int_options_reg <= `RST_INT_OPTIONS;
            state_reg <= ST_IDLE;
            bit_cnt_reg <= 4'h0;
            shift_reg <= 8'h00;
            rw_reg <= 1'b0;
            byte_idx_reg <= 2'h0;
            pointer_reg <= 8'h00;
            hold_hi_reg <= 8'h00;
            lo_sent_reg <= 1'b0;
            sda_oe_n_reg <= 1'b1;
        end else if (bus_start) begin
            state_reg <= ST_ADDR;
            bit_cnt_reg <= 4'h0;
            byte_idx_reg <= 2'h0;
            sda_oe_n_reg <= 1'b1;
        end else if (bus_stop) begin
            state_reg <= ST_IDLE;
            sda_oe_n_reg <= 1'b1;
        end else begin
            case (state_reg)
                ST_ADDR, ST_RX: begin
                    if (scl_rise) begin
                        shift_reg <= {shift_reg[6:0], sda_reg};
                        bit_cnt_reg <= bit_cnt_reg + 4'h1;
                    end else if (scl_fall && bit_cnt_reg == `BITS_PER_BYTE) begin
                        bit_cnt_reg <= 4'h0;
                        if (state_reg == ST_ADDR) begin
                            if (shift_reg[7:1] == DEV_ADDR) begin
                                rw_reg <= shift_reg[0];
                                sda_oe_n_reg <= 1'b0;
                                state_reg <= ST_ACK;
                            end else begin
                                state_reg <= ST_IDLE;
                            end
                        end else begin
                            sda_oe_n_reg <= 1'b0;
                            state_reg <= ST_ACK;
                            case (byte_idx_reg)
                                2'h0: begin
                                    pointer_reg <= shift_reg;
                                    byte_idx_reg <= 2'h1;
                                end
                                2'h1: begin
                                    hold_hi_reg <= shift_reg;
                                    byte_idx_reg <= 2'h2;
                                end
                                default: begin
                                    // whole word stored, reserved bits too
                                    case (pointer_reg)
                                        `ADDR_WINDOW: window_reg <= {hold_hi_reg, shift_reg};
                                        `ADDR_CHAIN: chain_reg <= {hold_hi_reg, shift_reg};
                                        `ADDR_INT_ENABLE:
                                            int_enable_reg <= {hold_hi_reg, shift_reg};
                                        `ADDR_INT_OPTIONS:
                                            int_options_reg <= {hold_hi_reg, shift_reg};
                                        default: window_reg <= window_reg;
                                    endcase
                                    pointer_reg <= pointer_next;
                                    byte_idx_reg <= 2'h1;
                                end
                            endcase
                        end
                    end
                end
                ST_ACK: begin
                    if (scl_fall) begin
                        bit_cnt_reg <= 4'h0;
                        if (rw_reg) begin
                            // first byte of a read is the high byte
                            shift_reg <= rd_word[15:8];
                            sda_oe_n_reg <= rd_word[15];
                            lo_sent_reg <= 1'b0;
                            state_reg <= ST_TX;
                        end else begin
                            sda_oe_n_reg <= 1'b1;
                            state_reg <= ST_RX;
                        end
                    end
                end
                ST_TX: begin
                    if (scl_fall) begin
                        if (bit_cnt_reg == `LAST_TX_BIT) begin
                            sda_oe_n_reg <= 1'b1;
                            state_reg <= ST_MACK;
                        end else begin
                            shift_reg <= {shift_reg[6:0], 1'b0};
                            sda_oe_n_reg <= shift_reg[6];
                            bit_cnt_reg <= bit_cnt_reg + 4'h1;
                        end
                    end
                end
                ST_MACK: begin
                    if (scl_rise && sda_reg) begin
                        state_reg <= ST_IDLE; // host nack ends the read
                    end else if (scl_fall) begin
                        bit_cnt_reg <= 4'h0;
                        state_reg <= ST_TX;
                        if (!lo_sent_reg) begin
                            shift_reg <= rd_word[7:0];
                            sda_oe_n_reg <= rd_word[7];
                            lo_sent_reg <= 1'b1;
                        end else begin
                            shift_reg <= rd_next_word[15:8];
                            sda_oe_n_reg <= rd_next_word[15];
                            pointer_reg <= pointer_next;
                            lo_sent_reg <= 1'b0;
                        end
                    end
                end
                default: sda_oe_n_reg <= 1'b1;
            endcase
        end
    end

    // ****************************************
    // decoded configuration outputs
    // ****************************************
    reg first_int_reg, second_int_reg, first_pair_reg, second_pair_reg, gap_reg;
    reg mode_normal_reg, mode_digital_reg;
    reg [4:0] first_gap_reg, second_gap_reg, width_reg;
    reg [10:0] start_reg;
    reg [7:0] mode_reg, ch1_kohm_reg, ch2_kohm_reg, ch3_kohm_reg, ch4_kohm_reg;

    wire [1:0] shared_gain;
    wire ind_gain;
    wire [4:0] fine_delay;

    assign shared_gain = chain_reg[`GAIN_MSB:`GAIN_LSB];
    assign ind_gain = chain_reg[`IND_GAIN_BIT];
    assign fine_delay = window_reg[`FINE_MSB:`FINE_LSB];

    // registered view of the fields
    always @(posedge I_SYS_CLK or negedge I_RST_N) begin
        if (!I_RST_N) begin
            first_int_reg <= 1'b0;
            second_int_reg <= 1'b0;
            first_pair_reg <= 1'b0;
            second_pair_reg <= 1'b0;
            gap_reg <= 1'b0;
            first_gap_reg <= 5'h00;
            second_gap_reg <= 5'h00;
            width_reg <= 5'h00;
            start_reg <= 11'h000;
            mode_reg <= 8'h00;
            mode_normal_reg <= 1'b0;
            mode_digital_reg <= 1'b0;
            ch1_kohm_reg <= 8'h00;
            ch2_kohm_reg <= 8'h00;
            ch3_kohm_reg <= 8'h00;
            ch4_kohm_reg <= 8'h00;
        end else begin
            second_int_reg <= int_enable_reg[`SECOND_INT_BIT];
            first_int_reg <= int_enable_reg[`FIRST_INT_BIT];
            gap_reg <= int_options_reg[`GAP_BIT];
            // gap is zero unless gapped, else the fine offset in us
            first_gap_reg <= int_options_reg[`GAP_BIT] ? fine_delay : 5'h00;
            second_gap_reg <= int_options_reg[`GAP_BIT] ?
                I_SECOND_SLOT_WINDOW_FINE_DELAY : 5'h00;
            second_pair_reg <= int_options_reg[`SECOND_PAIR_BIT];
            first_pair_reg <= int_options_reg[`FIRST_PAIR_BIT];
            width_reg <= window_reg[`WIDTH_MSB:`WIDTH_LSB];
            // start in 31.25 ns units: coarse times 32 plus fine
            start_reg <= {window_reg[`COARSE_MSB:`COARSE_LSB], 5'h00} + {6'h00, fine_delay};
            mode_reg <= chain_reg[`MODE_MSB:`MODE_LSB];
            mode_normal_reg <= chain_reg[`MODE_MSB:`MODE_LSB] == `CHAIN_NORMAL;
            mode_digital_reg <= chain_reg[`MODE_MSB:`MODE_LSB] == `CHAIN_DIGITAL;
            // channel 1 always local, others outside when per-channel
            ch1_kohm_reg <= gain_kohm(shared_gain);
            ch2_kohm_reg <= gain_kohm(ind_gain ? I_FIRST_SLOT_CH_GAIN[1:0] : shared_gain);
            ch3_kohm_reg <= gain_kohm(ind_gain ? I_FIRST_SLOT_CH_GAIN[3:2] : shared_gain);
            ch4_kohm_reg <= gain_kohm(ind_gain ? I_FIRST_SLOT_CH_GAIN[5:4] : shared_gain);
        end
    end

    // ****************************************
    // output drive
    // ****************************************
    assign O_SDA_OUT = 1'b0; // open drain, only ever pulls low
    assign O_SDA_OE_N = sda_oe_n_reg;
    assign O_FIRST_SLOT_INTEGRATE_SELECT = first_int_reg;
    assign O_SECOND_SLOT_INTEGRATE_SELECT = second_int_reg;
    assign O_FIRST_SLOT_PAIR_COUNT_SELECT = first_pair_reg;
    assign O_SECOND_SLOT_PAIR_COUNT_SELECT = second_pair_reg;
    assign O_INTEGRATE_GAP_ENABLE = gap_reg;
    assign O_FIRST_SLOT_GAP_US = first_gap_reg;
    assign O_SECOND_SLOT_GAP_US = second_gap_reg;
    assign O_FIRST_SLOT_WINDOW_WIDTH = width_reg;
    assign O_FIRST_SLOT_WINDOW_START = start_reg;
    assign O_FIRST_SLOT_CHAIN_MODE = mode_reg;
    assign O_FIRST_SLOT_CHAIN_NORMAL = mode_normal_reg;
    assign O_FIRST_SLOT_CHAIN_DIGITAL = mode_digital_reg;
    assign O_CH1_GAIN_KOHM = ch1_kohm_reg;
    assign O_CH2_GAIN_KOHM = ch2_kohm_reg;
    assign O_CH3_GAIN_KOHM = ch3_kohm_reg;
    assign O_CH4_GAIN_KOHM = ch4_kohm_reg;

endmodule

/* File: tb/slot_cfg_assertions.sv */
// checker on the ports of the slot configuration bank
// assumes: bound into the bank top, one clock, async low reset
`timescale 1ns/1ps
module slot_cfg_checker (
    // clock and reset
    input wire I_SYS_CLK,
    input wire I_RST_N,
    // watched ports
    input wire [4:0] I_SECOND_SLOT_WINDOW_FINE_DELAY,
    input wire [5:0] I_FIRST_SLOT_CH_GAIN,
    input wire O_INTEGRATE_GAP_ENABLE,
    input wire [4:0] O_FIRST_SLOT_GAP_US,
    input wire [4:0] O_SECOND_SLOT_GAP_US,
    input wire [4:0] O_FIRST_SLOT_WINDOW_WIDTH,
    input wire [10:0] O_FIRST_SLOT_WINDOW_START,
    input wire [7:0] O_FIRST_SLOT_CHAIN_MODE,
    input wire O_FIRST_SLOT_CHAIN_NORMAL,
    input wire O_FIRST_SLOT_CHAIN_DIGITAL,
    input wire [7:0] O_CH1_GAIN_KOHM,
    input wire [7:0] O_CH2_GAIN_KOHM,
    input wire [7:0] O_CH3_GAIN_KOHM,
    input wire [7:0] O_CH4_GAIN_KOHM
);
    default clocking cb @(posedge I_SYS_CLK);
    endclocking
    default disable iff (!I_RST_N);
    // gain fields one clock back, matching output latency
    reg [5:0] gain_reg;
    always @(posedge I_SYS_CLK) begin
        gain_reg <= I_FIRST_SLOT_CH_GAIN;
    end
    // ********
    // properties
    // ********
    a_gap_off_zero: assert property (!O_INTEGRATE_GAP_ENABLE |->
        O_FIRST_SLOT_GAP_US == 5'h00 && O_SECOND_SLOT_GAP_US == 5'h00)
        else $error("gap not zero while off");
    a_gap_first_fine: assert property (O_INTEGRATE_GAP_ENABLE |->
        O_FIRST_SLOT_GAP_US == O_FIRST_SLOT_WINDOW_START[4:0])
        else $error("first gap differs from fine delay");
    a_gap_second_fine: assert property (O_INTEGRATE_GAP_ENABLE |->
        O_SECOND_SLOT_GAP_US == $past(I_SECOND_SLOT_WINDOW_FINE_DELAY))
        else $error("second gap differs from fine delay");
    a_normal_mode_decode: assert property (
        O_FIRST_SLOT_CHAIN_NORMAL == (O_FIRST_SLOT_CHAIN_MODE == 8'h1C))
        else $error("normal flag wrong");
    a_digital_mode_decode: assert property (
        O_FIRST_SLOT_CHAIN_DIGITAL == (O_FIRST_SLOT_CHAIN_MODE == 8'h1D))
        else $error("digital flag wrong");
    a_gain_code_legal: assert property ($past(I_RST_N) |->
        O_CH1_GAIN_KOHM inside {8'hC8, 8'h64, 8'h32, 8'h19})
        else $error("gain value off the code table");
    a_gain_source: assert property (
        (O_CH2_GAIN_KOHM == O_CH1_GAIN_KOHM && O_CH3_GAIN_KOHM == O_CH1_GAIN_KOHM
        && O_CH4_GAIN_KOHM == O_CH1_GAIN_KOHM) || (O_CH2_GAIN_KOHM == 8'hC8 >> gain_reg[1:0]
        && O_CH3_GAIN_KOHM == 8'hC8 >> gain_reg[3:2] && O_CH4_GAIN_KOHM == 8'hC8 >> gain_reg[5:4]))
        else $error("channel gains neither shared nor individual");
    a_reset_defaults: assert property ($rose(I_RST_N) |=>
        O_FIRST_SLOT_WINDOW_WIDTH == 5'h04 && O_FIRST_SLOT_WINDOW_START == 11'h2FC
        && O_FIRST_SLOT_CHAIN_MODE == 8'h1C) else $error("window defaults wrong");
    c_gap_on: cover property (O_INTEGRATE_GAP_ENABLE);
    c_digital: cover property (O_FIRST_SLOT_CHAIN_DIGITAL);
    c_indiv_gain: cover property (O_CH2_GAIN_KOHM != O_CH1_GAIN_KOHM);
endmodule
bind afe_slot_timing_mode_config slot_cfg_checker chk (
    .I_SYS_CLK, .I_RST_N, .I_SECOND_SLOT_WINDOW_FINE_DELAY, .I_FIRST_SLOT_CH_GAIN,
    .O_INTEGRATE_GAP_ENABLE, .O_FIRST_SLOT_GAP_US, .O_SECOND_SLOT_GAP_US,
    .O_FIRST_SLOT_WINDOW_WIDTH, .O_FIRST_SLOT_WINDOW_START, .O_FIRST_SLOT_CHAIN_MODE,
    .O_FIRST_SLOT_CHAIN_NORMAL, .O_FIRST_SLOT_CHAIN_DIGITAL, .O_CH1_GAIN_KOHM,
    .O_CH2_GAIN_KOHM, .O_CH3_GAIN_KOHM, .O_CH4_GAIN_KOHM
);

/* File: tb/host_port_model.sv */
// host model on the two-wire register port
// assumes: data wire resolved outside with a pull-up; 8 clocks a bit
`timescale 1ns/1ps
module host_port_model #(
    parameter [6:0] DEV_ADDR = 7'h2A // arbitrary bus address
) (
    // clock and resolved wire
    input wire i_clk,
    input wire i_sda,
    // driven lines, oe low pulls the wire low
    output reg o_scl,
    output reg o_sda_oe_n
);
    reg [15:0] rd_data;
    event rd_ev;
    initial begin
        o_scl = 1'b1;
        o_sda_oe_n = 1'b1;
    end
    // ********
    // bus cycle tasks
    // ********
    // wait n edges, then step just past the edge
    task wt(input integer n);
        repeat (n) @(posedge i_clk);
        #2;
    endtask
    // one bit slot, wire sampled late in the high phase
    task bitx(input b, output r);
        wt(1);
        o_sda_oe_n = b;
        wt(3);
        o_scl = 1'b1;
        wt(4);
        r = i_sda;
        o_scl = 1'b0;
    endtask
    // start (1,0) or stop (0,1): data moves while clock is high
    task frame(input a, input b);
        wt(1);
        o_sda_oe_n = a;
        wt(3);
        o_scl = 1'b1;
        wt(4);
        o_sda_oe_n = b;
        wt(4);
        o_scl = b;
    endtask
    // eight bits msb first, then the acknowledge slot
    task xbyte(input [7:0] d, input a9, output [7:0] q, output r9);
        integer i;
        for (i = 7; i >= 0; i = i - 1)
            bitx(d[i], q[i]);
        bitx(a9, r9);
    endtask
    // word write, stops early when the address is refused
    task wr(input [6:0] dev, input [7:0] a, input [15:0] v, output ok);
        reg [7:0] q;
        reg n;
        frame(1'b1, 1'b0);
        xbyte({dev, 1'b0}, 1'b1, q, n);
        ok = !n;
        if (ok) begin
            xbyte(a, 1'b1, q, n);
            xbyte(v[15:8], 1'b1, q, n);
            xbyte(v[7:0], 1'b1, q, n);
        end
        frame(1'b0, 1'b1);
    endtask
    // word read through a repeated start, last byte refused
    task rd(input [7:0] a);
        reg [7:0] q;
        reg n;
        frame(1'b1, 1'b0);
        xbyte({DEV_ADDR, 1'b0}, 1'b1, q, n);
        xbyte(a, 1'b1, q, n);
        frame(1'b1, 1'b0);
        xbyte({DEV_ADDR, 1'b1}, 1'b1, q, n);
        xbyte(8'hFF, 1'b0, rd_data[15:8], n);
        xbyte(8'hFF, 1'b1, rd_data[7:0], n);
        frame(1'b0, 1'b1);
        ->rd_ev;
    endtask
endmodule

/* File: tb/tb_top.sv */
// self-checking bench for the slot configuration bank
// assumes: host model on the serial port, pull-up on the data wire
`timescale 1ns/1ps
`include "afe_slot_cfg_defines.vh"
module tb_top;
    localparam [6:0] DEV = 7'h2A; // arbitrary bus address
    reg clk = 1'b0;
    reg rst_n = 1'b0;
    reg [5:0] ch_gain = 6'h00;
    reg [4:0] sec_fine = 5'h00;
    reg [15:0] win, chn, ien, opt, obs;
    reg [7:0] ra [0:3];
    reg [15:0] rv [0:3];
    reg [15:0] exp_q [$];
    reg ok;
    integer i;
    integer err_total = 0;
    integer n_tests = 0;
    integer seed = 32'h2DA1F06F;
    event obs_ev;
    wire scl, host_oe_n, sda_out, sda_oe_n, sda;
    wire int1, int2, pair1, pair2, gap_en, norm, dig;
    wire [4:0] gap1, gap2, width;
    wire [10:0] start;
    wire [7:0] mode, g1, g2, g3, g4;
    // open-drain wire with pull-up
    assign sda = host_oe_n & (sda_oe_n | sda_out);
    always #12.5 clk = ~clk;
    afe_slot_timing_mode_config #(.DEV_ADDR(DEV)) uut (
        .I_SYS_CLK(clk), .I_RST_N(rst_n), .I_SCL(scl), .I_SDA(sda),
        .O_SDA_OUT(sda_out), .O_SDA_OE_N(sda_oe_n), .I_FIRST_SLOT_CH_GAIN(ch_gain),
        .I_SECOND_SLOT_WINDOW_FINE_DELAY(sec_fine), .O_FIRST_SLOT_INTEGRATE_SELECT(int1),
        .O_SECOND_SLOT_INTEGRATE_SELECT(int2), .O_FIRST_SLOT_PAIR_COUNT_SELECT(pair1),
        .O_SECOND_SLOT_PAIR_COUNT_SELECT(pair2), .O_INTEGRATE_GAP_ENABLE(gap_en),
        .O_FIRST_SLOT_GAP_US(gap1), .O_SECOND_SLOT_GAP_US(gap2),
        .O_FIRST_SLOT_WINDOW_WIDTH(width), .O_FIRST_SLOT_WINDOW_START(start),
        .O_FIRST_SLOT_CHAIN_MODE(mode), .O_FIRST_SLOT_CHAIN_NORMAL(norm),
        .O_FIRST_SLOT_CHAIN_DIGITAL(dig), .O_CH1_GAIN_KOHM(g1), .O_CH2_GAIN_KOHM(g2),
        .O_CH3_GAIN_KOHM(g3), .O_CH4_GAIN_KOHM(g4)
    );
    host_port_model #(.DEV_ADDR(DEV)) host (
        .i_clk(clk), .i_sda(sda), .o_scl(scl), .o_sda_oe_n(host_oe_n)
    );
    // ********
    // result watcher and helpers
    // ********
    task cmp(input [15:0] got);
        reg [15:0] e;
        e = exp_q.pop_front();
        n_tests = n_tests + 1;
        if (got !== e) begin
            err_total = err_total + 1;
            $display("wrong value at %0t: got %h expected %h", $time, got, e);
        end
    endtask
    always @(host.rd_ev) cmp(host.rd_data);
    always @(obs_ev) cmp(obs);
    // note the expectation, then hand the observed value over
    task ob(input [15:0] e, input [15:0] got);
        exp_q.push_back(e);
        obs = got;
        ->obs_ev;
        #1;
    endtask
    task rchk(input [7:0] a, input [15:0] e);
        exp_q.push_back(e);
        host.rd(a);
        // let the read watcher take its note before anything else is queued
        host.wt(1);
    endtask
    task put(input [7:0] a, input [15:0] v);
        host.wr(DEV, a, v, ok);
        rchk(a, v);
    endtask
    // decoded outputs against the register images
    task chkdec;
        reg [7:0] k1;
        k1 = 8'hC8 >> chn[1:0];
        ob({11'h0, win[15:11]}, {11'h0, width});
        ob({5'h0, win[10:0]}, {5'h0, start});
        ob({8'h0, chn[15:8]}, {8'h0, mode});
        ob({14'h0, chn[15:8] == 8'h1D, chn[15:8] == 8'h1C}, {14'h0, dig, norm});
        ob({12'h0, ien[13:12], opt[6:5]}, {12'h0, int2, int1, pair2, pair1});
        ob({15'h0, opt[7]}, {15'h0, gap_en});
        ob(opt[7] ? {6'h0, sec_fine, win[4:0]} : 16'h0, {6'h0, gap2, gap1});
        ob({k1, (chn[6] ? (8'hC8 >> ch_gain[1:0]) : k1)}, {g1, g2});
        ob(chn[6] ? {8'hC8 >> ch_gain[3:2], 8'hC8 >> ch_gain[5:4]} : {k1, k1}, {g3, g4});
        host.wt(1);
    endtask
    task print_verdict;
        $display("comparisons %0d mismatches %0d", n_tests, err_total);
        if (err_total == 0 && n_tests > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
    // ********
    // main sequence, run twice around a mid-run reset
    // ********
    initial begin
        ra = '{`ADDR_WINDOW, `ADDR_CHAIN, `ADDR_INT_ENABLE, `ADDR_INT_OPTIONS};
        rv = '{`RST_WINDOW, `RST_CHAIN, `RST_INT_ENABLE, `RST_INT_OPTIONS};
        repeat (2) begin
            repeat (16) @(posedge clk);
            #2;
            rst_n = 1'b1;
            host.wt(4);
            for (i = 0; i < 4; i = i + 1)
                rchk(ra[i], rv[i]);
            win = rv[0];
            chn = rv[1];
            ien = rv[2];
            opt = rv[3];
            chkdec;
            // every gain code with and without per-channel gains
            for (i = 0; i < 8; i = i + 1) begin
                win = 16'($random(seed));
                chn = 16'($random(seed));
                ien = 16'($random(seed));
                opt = 16'($random(seed));
                chn[15:8] = 8'h1C + {6'h00, i[1:0]};
                chn[6] = i[2];
                chn[1:0] = i[1:0];
                opt[7] = i[0];
                ch_gain = 6'($random(seed));
                sec_fine = 5'($random(seed));
                put(`ADDR_WINDOW, win);
                put(`ADDR_CHAIN, chn);
                put(`ADDR_INT_ENABLE, ien);
                put(`ADDR_INT_OPTIONS, opt);
                chkdec;
            end
            // unmapped place, then a foreign bus address
            host.wr(DEV, 8'h40, 16'hA5A5, ok);
            rchk(8'h40, 16'h0000);
            host.wr(DEV ^ 7'h01, `ADDR_INT_ENABLE, ~ien, ok);
            ob(16'h0000, {15'h0, ok});
            rchk(`ADDR_INT_ENABLE, ien);
            rst_n = 1'b0;
        end
        print_verdict;
    end
    // hang guard
    initial begin
        repeat (95000) @(posedge clk);
        err_total = err_total + 1;
        print_verdict;
    end
endmodule
